// file: hw/thermal_pkg.sv
// What this block does
// - Pointer resets to the capability register.
// - Capability register reads fixed 00F7h.
// - Bus options register resets to 21h.
// - Trip limits and hysteresis reset to zero.
// - Alert output starts disabled, comparator, active low.
// - Clock held low too long returns bus idle.
// - Timeout on by default, bit 7 disables.
// - Device never drives the clock line.
// - Alert response only in interrupt, low polarity.
// - Alerting device answers alert read with address.
// - Arbitrate alert answer; winner releases alert.
// - Alert response off by default, bit 0.
// - Pointer holds last written location.
// - Writes carry pointer, then two data bytes.
// - Reads use current pointer or pointer-then-restart.
// - Bytes go MSB first, high byte first.
// - Host acknowledge or not-acknowledge ends reads properly.
// - Each register enforces its access type.
// - Temperature updates at most once per 125 ms.
package thermal_pkg;
    // ************************************************************
    // Register map.
    // ************************************************************
    localparam logic [7:0] OFS_CAPABILITY = 8'h00;
    localparam logic [7:0] OFS_CONFIGURATION = 8'h01;
    localparam logic [7:0] OFS_UPPER_LIMIT = 8'h02;
    localparam logic [7:0] OFS_LOWER_LIMIT = 8'h03;
    localparam logic [7:0] OFS_CRITICAL_LIMIT = 8'h04;
    localparam logic [7:0] OFS_TEMPERATURE = 8'h05;
    localparam logic [7:0] OFS_BUS_OPTIONS = 8'h22;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [15:0] CAPABILITY_VALUE = 16'h00F7;
    localparam logic [15:0] CONFIGURATION_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [15:0] BUS_OPTIONS_RESET = 16'h0021;
    localparam logic [15:0] TEMPERATURE_RESET = 16'h0000;
    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int CFG_MODE_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int CFG_EN_BIT = 3;
    localparam int CFG_CLR_BIT = 5;
    localparam int OPT_ARA_DIS_BIT = 0;
    localparam int OPT_TOUT_DIS_BIT = 7;
    // ************************************************************
    // Bus constants.
    // ************************************************************
    localparam logic [7:0] ARA_READ_BYTE = 8'h19;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int TIMEOUT_MS = 35;
    localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_FREQ_HZ / 1000);
    localparam int CONVERSION_MS = 125;
    localparam int CONVERSION_CYCLES = CONVERSION_MS * (CLK_FREQ_HZ / 1000);
endpackage : thermal_pkg

// file: hw/thermal_sensor_smbus_slave.sv
`timescale 1ns/10ps
module thermal_sensor_smbus_slave #(
    parameter logic [6:0] SLAVE_ADDR = 7'h18,
    parameter int TIMEOUT_CYCLES = thermal_pkg::TIMEOUT_CYCLES,
    parameter int CONVERSION_CYCLES = thermal_pkg::CONVERSION_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic alert_o,
    output logic alert_oe_o,
    input wire logic [15:0] temp_value_i,
    input wire logic alarm_event_i
);
    import thermal_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_ARA
    } state_type;

    state_type state;
    logic link_bit;
    logic link_tgl;
    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic tgl_s1, tgl_s2, tgl_s3;
    logic [3:0] bit_cnt;
    logic byte_idx;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic [7:0] rd_lsb;
    logic [7:0] wr_msb;
    logic [7:0] pointer;
    logic [15:0] configuration;
    logic [15:0] upper_alarm_limit;
    logic [15:0] lower_alarm_limit;
    logic [15:0] critical_limit;
    logic [15:0] bus_options;
    logic [15:0] temperature;
    logic [15:0] read_word;
    logic [31:0] low_cnt;
    logic [31:0] conv_cnt;
    logic alert_latch;
    logic alarm_prev;
    logic scl_fall, start_seen, stop_seen, bit_tick, timeout_hit, bus_abort;
    logic byte_end, sending, addr_hit, ara_hit, ack_now;
    logic ptr_store, wr_commit, ara_win, alert_asserted;

    // ************************************************************
    // Link clock domain: sample the data line on each clock rise.
    // ************************************************************
    always_ff @(posedge scl_i) begin
        if (!rst_n_i) begin
            link_bit <= 1'b1;
            link_tgl <= 1'b0;
        end else begin
            link_bit <= sda_i;
            link_tgl <= ~link_tgl;
        end
    end

    // ************************************************************
    // Synchronisers into the system clock domain.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
            tgl_s1 <= 1'b0;
            tgl_s2 <= 1'b0;
            tgl_s3 <= 1'b0;
        end else begin
            scl_s1 <= scl_i;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_i;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
            tgl_s1 <= link_tgl;
            tgl_s2 <= tgl_s1;
            tgl_s3 <= tgl_s2;
        end
    end

    assign scl_fall = scl_s3 & ~scl_s2;
    assign start_seen = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign stop_seen = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    assign bit_tick = tgl_s2 ^ tgl_s3;
    assign bus_abort = timeout_hit | stop_seen | start_seen;
    assign byte_end = bit_tick & (bit_cnt == ACK_SLOT) & ~bus_abort;
    assign sending = (state == ST_RDATA) | (state == ST_ARA);
    assign addr_hit = rx_shift[7:1] == SLAVE_ADDR;
    assign alert_asserted = configuration[CFG_MODE_BIT] ? alert_latch : alarm_event_i;
    assign ara_hit = (rx_shift == ARA_READ_BYTE) & ~bus_options[OPT_ARA_DIS_BIT]
        & configuration[CFG_MODE_BIT] & ~configuration[CFG_POL_BIT] & alert_asserted;
    assign ptr_store = byte_end & (state == ST_PTR);
    assign wr_commit = byte_end & (state == ST_WDATA) & byte_idx;
    assign ara_win = byte_end & (state == ST_ARA);

    always_comb begin
        unique case (state)
            ST_ADDR: ack_now = addr_hit | ara_hit;
            ST_PTR: ack_now = 1'b1;
            ST_WDATA: ack_now = 1'b1;
            default: ack_now = 1'b0;
        endcase
    end

    // ************************************************************
    // Clock low timeout.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || scl_s2 || bus_options[OPT_TOUT_DIS_BIT]) begin
            low_cnt <= 32'h0;
        end else if (timeout_hit) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= low_cnt + 32'h1;
        end
    end

    assign timeout_hit = (low_cnt == 32'(TIMEOUT_CYCLES - 1));

    // ************************************************************
    // Protocol state machine.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || timeout_hit || stop_seen) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            byte_idx <= 1'b0;
        end else if (start_seen) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            byte_idx <= 1'b0;
        end else if (bit_tick && state != ST_IDLE) begin
            if (bit_cnt != ACK_SLOT) begin
                bit_cnt <= bit_cnt + 4'h1;
                rx_shift <= {rx_shift[6:0], link_bit};
                tx_shift <= {tx_shift[6:0], 1'b0};
                if (state == ST_ARA && tx_shift[7] && !link_bit) begin
                    state <= ST_IDLE;
                end
            end else begin
                bit_cnt <= 4'h0;
                unique case (state)
                    ST_ADDR: begin
                        if (addr_hit && rx_shift[0]) begin
                            state <= ST_RDATA;
                            tx_shift <= read_word[15:8];
                            rd_lsb <= read_word[7:0];
                            byte_idx <= 1'b0;
                        end else if (addr_hit) begin
                            state <= ST_PTR;
                        end else if (ara_hit) begin
                            state <= ST_ARA;
                            tx_shift <= {SLAVE_ADDR, 1'b0};
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_PTR: begin
                        state <= ST_WDATA;
                        byte_idx <= 1'b0;
                    end
                    ST_WDATA: begin
                        if (!byte_idx) begin
                            wr_msb <= rx_shift;
                            byte_idx <= 1'b1;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_RDATA: begin
                        if (link_bit || byte_idx) begin
                            state <= ST_IDLE;
                        end else begin
                            tx_shift <= rd_lsb;
                            byte_idx <= 1'b1;
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // ************************************************************
    // Data line drive, changed only while the clock is low.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || bus_abort) begin
            sda_oe_o <= 1'b0;
        end else if (scl_fall) begin
            if (bit_cnt == ACK_SLOT) begin
                sda_oe_o <= ack_now & ~sending;
            end else begin
                sda_oe_o <= sending & ~tx_shift[7];
            end
        end
    end

    // The clock line has no driver at all; the open-drain data and alert outputs are both low.
    always_ff @(posedge clk_sys_i) begin
        sda_o <= 1'b0;
        alert_o <= 1'b0;
    end

    // ************************************************************
    // Pointer and data registers.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            pointer <= PTR_RESET;
        end else if (ptr_store) begin
            pointer <= rx_shift;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            configuration <= CONFIGURATION_RESET;
            upper_alarm_limit <= LIMIT_RESET;
            lower_alarm_limit <= LIMIT_RESET;
            critical_limit <= LIMIT_RESET;
            bus_options <= BUS_OPTIONS_RESET;
        end else if (wr_commit) begin
            unique case (pointer)
                OFS_CONFIGURATION: begin
                    configuration <= {wr_msb, rx_shift};
                    configuration[CFG_CLR_BIT] <= 1'b0;
                end
                OFS_UPPER_LIMIT: upper_alarm_limit <= {wr_msb, rx_shift};
                OFS_LOWER_LIMIT: lower_alarm_limit <= {wr_msb, rx_shift};
                OFS_CRITICAL_LIMIT: critical_limit <= {wr_msb, rx_shift};
                OFS_BUS_OPTIONS: bus_options <= {wr_msb, rx_shift};
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (pointer)
            OFS_CAPABILITY: read_word = CAPABILITY_VALUE;
            OFS_CONFIGURATION: read_word = configuration;
            OFS_UPPER_LIMIT: read_word = upper_alarm_limit;
            OFS_LOWER_LIMIT: read_word = lower_alarm_limit;
            OFS_CRITICAL_LIMIT: read_word = critical_limit;
            OFS_TEMPERATURE: read_word = temperature;
            OFS_BUS_OPTIONS: read_word = bus_options;
            default: read_word = 16'h0000;
        endcase
    end

    // ************************************************************
    // Temperature capture once per conversion period.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i || conv_cnt == 32'(CONVERSION_CYCLES - 1)) begin
            conv_cnt <= 32'h0;
        end else begin
            conv_cnt <= conv_cnt + 32'h1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            temperature <= TEMPERATURE_RESET;
        end else if (conv_cnt == 32'(CONVERSION_CYCLES - 1)) begin
            temperature <= temp_value_i;
        end
    end

    // ************************************************************
    // Alert state and open-drain alert pin.
    // ************************************************************
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            alarm_prev <= 1'b0;
            alert_latch <= 1'b0;
        end else begin
            alarm_prev <= alarm_event_i;
            if (alarm_event_i && !alarm_prev) begin
                alert_latch <= 1'b1;
            end else if (ara_win) begin
                alert_latch <= 1'b0;
            end else if (wr_commit && pointer == OFS_CONFIGURATION && rx_shift[CFG_CLR_BIT]) begin
                alert_latch <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            alert_oe_o <= 1'b0;
        end else begin
            alert_oe_o <= configuration[CFG_EN_BIT] & (alert_asserted ^ configuration[CFG_POL_BIT]);
        end
    end

    // ************************************************************
    // Checks.
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    reset_defaults_a: assert property ($rose(rst_n_i) |-> pointer == PTR_RESET
        && bus_options == BUS_OPTIONS_RESET && critical_limit == LIMIT_RESET
        && upper_alarm_limit == LIMIT_RESET && !alert_oe_o)
        else $error("Reset defaults wrong.");
    bus_opt_reset_a: assert property ($rose(rst_n_i) |-> bus_options == 16'h0021)
        else $error("Bus options reset value wrong.");
    cap_read_a: assert property (byte_end && state == ST_ADDR && addr_hit && rx_shift[0]
        && pointer == OFS_CAPABILITY |=> tx_shift == 8'h00 && rd_lsb == 8'hF7)
        else $error("Capability word wrong.");
    timeout_idle_a: assert property (timeout_hit |=> state == ST_IDLE && !sda_oe_o)
        else $error("Timeout did not idle the bus.");
    timeout_off_a: assert property (bus_options[OPT_TOUT_DIS_BIT] |-> !timeout_hit)
        else $error("Timeout fired while disabled.");
    ara_gate_a: assert property (byte_end && state == ST_ADDR && !addr_hit
        ##1 state == ST_ARA |-> configuration[CFG_MODE_BIT] && !configuration[CFG_POL_BIT])
        else $error("Alert response answered in wrong mode.");
    ara_release_a: assert property (ara_win && !(alarm_event_i && !alarm_prev)
        |=> !alert_latch)
        else $error("Alert not released after win.");
    ptr_hold_a: assert property (!ptr_store |=> $stable(pointer))
        else $error("Pointer changed without a pointer byte.");
    nack_end_a: assert property (byte_end && state == ST_RDATA && link_bit
        |=> state == ST_IDLE ##1 !sda_oe_o)
        else $error("Read did not end on not-acknowledge.");
    msb_first_a: assert property (byte_end && state == ST_ADDR && addr_hit && rx_shift[0]
        |=> tx_shift == $past(read_word[15:8]) && rd_lsb == $past(read_word[7:0]))
        else $error("Word order wrong.");
    temp_rate_a: assert property ($changed(temperature)
        |-> $past(conv_cnt) == 32'(CONVERSION_CYCLES - 1))
        else $error("Temperature updated early.");
    clear_event_a: assert property (wr_commit && pointer == OFS_CONFIGURATION
        && rx_shift[CFG_CLR_BIT] && !(alarm_event_i && !alarm_prev) |=> !alert_latch)
        else $error("Clear event bit did not clear the alert.");
    clear_reads_zero_a: assert property (!configuration[CFG_CLR_BIT])
        else $error("Clear event bit read back as one.");
    host_ack_slot_a: assert property (sending && scl_fall && bit_cnt == ACK_SLOT
        |=> !sda_oe_o)
        else $error("Data line held during the host acknowledge slot.");
    drive_clock_low_a: assert property ($rose(sda_oe_o) |-> !scl_s3)
        else $error("Data line pulled while the clock was high.");
    ara_reply_a: assert property (byte_end && state == ST_ADDR && ara_hit && !addr_hit
        |=> state == ST_ARA && tx_shift == {SLAVE_ADDR, 1'b0})
        else $error("Alert response did not load the own address.");
    alert_enable_a: assert property (!configuration[CFG_EN_BIT] |=> !alert_oe_o)
        else $error("Alert pin driven while disabled.");
    ara_disabled_a: assert property (byte_end && state == ST_ADDR && !addr_hit
        && bus_options[OPT_ARA_DIS_BIT] |=> state != ST_ARA)
        else $error("Alert response answered while disabled.");

    // ************************************************************
    // Cover points.
    // ************************************************************
    read_seen_c: cover property (state == ST_RDATA ##[1:1000] state == ST_IDLE);
    write_seen_c: cover property (wr_commit);
    ara_seen_c: cover property (ara_win);
    timeout_seen_c: cover property (timeout_hit);
    clear_seen_c: cover property (wr_commit && pointer == OFS_CONFIGURATION
        && rx_shift[CFG_CLR_BIT]);
endmodule : thermal_sensor_smbus_slave

// file: bench/host_bfm.sv
`timescale 1ns/10ps
module host_bfm (
    output logic scl_o,
    output logic sda_pull_o,
    input wire logic sda_i
);
    // ************************************************************
    // Link clock, bit timing and bus conditions.
    // ************************************************************
    logic link_clk = 1'h0;
    initial begin
        scl_o = 1'h0;
        sda_pull_o = 1'h0;
        // One clock rise while reset is low puts the link flops in a known state.
        #30;
        scl_o = 1'h1;
        #3;
        forever #6 link_clk = ~link_clk;
    end
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge link_clk);
    endtask : wait_ticks
    task automatic half();
        wait_ticks(8);
    endtask : half
    task automatic start_cond();
        sda_pull_o = 1'h0;
        half();
        scl_o = 1'h1;
        half();
        sda_pull_o = 1'h1;
        half();
        scl_o = 1'h0;
    endtask : start_cond
    task automatic stop_cond();
        sda_pull_o = 1'h1;
        half();
        scl_o = 1'h1;
        half();
        sda_pull_o = 1'h0;
        half();
    endtask : stop_cond
    task automatic send_bit(input logic b, output logic seen);
        sda_pull_o = ~b;
        half();
        scl_o = 1'h1;
        half();
        seen = sda_i;
        scl_o = 1'h0;
        wait_ticks(2);
    endtask : send_bit
    // Bytes go out most significant bit first, then the acknowledge slot.
    task automatic xfer_byte(input logic [7:0] d, input logic ack_bit, output logic [7:0] q,
                             output logic ack_seen);
        for (int i = 7; i >= 0; i--) begin
            send_bit(d[i], q[i]);
        end
        send_bit(ack_bit, ack_seen);
    endtask : xfer_byte
endmodule : host_bfm

// file: bench/tb.sv
`timescale 1ns/10ps
module tb;
    import thermal_pkg::*;
    localparam logic [6:0] DEV = 7'h18;
    logic clk = 1'h0;
    logic rst_n, scl, host_pull, sda_val, sda_oe, alert_val, alert_oe, alarm_event;
    logic [15:0] temp_value;
    int num_errors = 0;
    int cmp_count = 0;
    wire sda_line = (host_pull || (sda_oe && !sda_val)) ? 1'h0 : 1'h1;
    wire alert_line = (alert_oe && !alert_val) ? 1'h0 : 1'h1;
    always #4 clk = ~clk;
    thermal_sensor_smbus_slave #(.SLAVE_ADDR(DEV), .TIMEOUT_CYCLES(2000),
        .CONVERSION_CYCLES(500)) thermal_sensor_smbus_slave_inst (
        .clk_sys_i(clk), .rst_n_i(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_val),
        .sda_oe_o(sda_oe), .alert_o(alert_val), .alert_oe_o(alert_oe),
        .temp_value_i(temp_value), .alarm_event_i(alarm_event));
    host_bfm host_bfm_inst (.scl_o(scl), .sda_pull_o(host_pull), .sda_i(sda_line));
    // ************************************************************
    // Shared bus and compare tasks.
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ptr, input logic [15:0] data, input bit with_data);
        logic [7:0] q;
        logic [3:0] a;
        a = 4'h0;
        host_bfm_inst.start_cond();
        host_bfm_inst.xfer_byte({DEV, 1'h0}, 1'h1, q, a[0]);
        host_bfm_inst.xfer_byte(ptr, 1'h1, q, a[1]);
        if (with_data) begin
            host_bfm_inst.xfer_byte(data[15:8], 1'h1, q, a[2]);
            host_bfm_inst.xfer_byte(data[7:0], 1'h1, q, a[3]);
        end
        host_bfm_inst.stop_cond();
        chk("write_ack", 16'h0000, {12'h000, a});
    endtask : wr
    task automatic rd(input logic [7:0] ptr, input bit set_ptr, input logic last_ack,
                      output logic [15:0] w);
        logic [7:0] q;
        logic [2:0] a;
        logic d;
        a = 3'h0;
        host_bfm_inst.start_cond();
        if (set_ptr) begin
            host_bfm_inst.xfer_byte({DEV, 1'h0}, 1'h1, q, a[0]);
            host_bfm_inst.xfer_byte(ptr, 1'h1, q, a[1]);
            host_bfm_inst.start_cond();
        end
        host_bfm_inst.xfer_byte({DEV, 1'h1}, 1'h1, q, a[2]);
        host_bfm_inst.xfer_byte(8'hFF, 1'h0, w[15:8], d);
        host_bfm_inst.xfer_byte(8'hFF, last_ack, w[7:0], d);
        host_bfm_inst.stop_cond();
        chk("read_ack", 16'h0000, {13'h0000, a});
    endtask : rd
    task automatic ara(input logic [7:0] drive, output logic ack, output logic [7:0] q);
        logic d;
        host_bfm_inst.start_cond();
        host_bfm_inst.xfer_byte(ARA_READ_BYTE, 1'h1, q, ack);
        if (ack === 1'h0) begin
            host_bfm_inst.xfer_byte(drive, 1'h1, q, d);
        end
        host_bfm_inst.stop_cond();
    endtask : ara
    task automatic alarm_pulse();
        @(negedge clk) alarm_event = 1'h0;
        repeat (3) @(negedge clk);
        alarm_event = 1'h1;
        repeat (5) @(negedge clk);
    endtask : alarm_pulse
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic test_defaults();
        logic [15:0] w;
        chk("alert_off", 16'h0001, {15'h0000, alert_line});
        rd(8'h00, 0, 1'h1, w);
        chk("pointer_reset", 16'h00F7, w);
        rd(OFS_CAPABILITY, 1, 1'h1, w);
        chk("capability", 16'h00F7, w);
        rd(OFS_CONFIGURATION, 1, 1'h1, w);
        chk("configuration", 16'h0000, w);
        for (int i = 2; i <= 4; i++) begin
            rd(8'(i), 1, 1'h1, w);
            chk("limit_reset", 16'h0000, w);
        end
        rd(OFS_BUS_OPTIONS, 1, 1'h1, w);
        chk("bus_options", 16'h0021, w);
        alarm_event = 1'h0;
    endtask : test_defaults
    task automatic test_write_read();
        logic [15:0] w;
        logic [15:0] vals [3] = '{16'h0550, 16'h1F40, 16'h05F0};
        for (int i = 0; i < 3; i++) begin
            wr(8'(i + 2), vals[i], 1);
        end
        for (int i = 0; i < 3; i++) begin
            rd(8'(i + 2), 1, (i == 0) ? 1'h0 : 1'h1, w);
            chk("limit_readback", vals[i], w);
        end
        rd(8'h00, 0, 1'h1, w);
        chk("pointer_held", vals[2], w);
        rd(8'h00, 0, 1'h1, w);
        chk("pointer_kept", vals[2], w);
        wr(OFS_UPPER_LIMIT, 16'h0000, 0);
        rd(8'h00, 0, 1'h1, w);
        chk("pointer_only", vals[0], w);
    endtask : test_write_read
    task automatic test_access();
        logic [15:0] w;
        wr(OFS_CAPABILITY, 16'h1234, 1);
        rd(OFS_CAPABILITY, 1, 1'h1, w);
        chk("capability_ro", 16'h00F7, w);
        wr(OFS_TEMPERATURE, 16'h0000, 1);
        rd(OFS_TEMPERATURE, 1, 1'h1, w);
        chk("temperature", 16'h0C3A, w);
    endtask : test_access
    task automatic test_timeout();
        logic s;
        for (int k = 0; k < 2; k++) begin
            host_bfm_inst.start_cond();
            for (int i = 7; i >= 0; i--) begin
                host_bfm_inst.send_bit(i > 0 && DEV[i - 1], s);
            end
            host_bfm_inst.wait_ticks(6);
            chk("ack_driven", 16'h0001, {15'h0000, sda_oe});
            host_bfm_inst.wait_ticks(1500);
            chk("scl_low_hold", {15'h0000, k[0]}, {15'h0000, sda_oe});
            if (k == 1) begin
                host_bfm_inst.send_bit(1'h1, s);
            end
            host_bfm_inst.stop_cond();
            wr(OFS_BUS_OPTIONS, 16'h00A1, 1);
        end
    endtask : test_timeout
    task automatic test_alert();
        logic ack;
        logic [7:0] q;
        logic [15:0] w;
        wr(OFS_CONFIGURATION, 16'h0009, 1);
        alarm_pulse();
        chk("int_latched", 16'h0000, {15'h0000, alert_line});
        ara(8'hFF, ack, q);
        chk("ara_default_off", 16'h0001, {15'h0000, ack});
        wr(OFS_BUS_OPTIONS, 16'h0020, 1);
        ara(8'h00, ack, q);
        chk("ara_ack", 16'h0000, {15'h0000, ack});
        chk("ara_lost", 16'h0000, {15'h0000, alert_line});
        ara(8'hFF, ack, q);
        chk("ara_reply", {8'h00, DEV, 1'h0}, {8'h00, q});
        chk("ara_won", 16'h0001, {15'h0000, alert_line});
        alarm_pulse();
        chk("int_relatched", 16'h0000, {15'h0000, alert_line});
        wr(OFS_CONFIGURATION, 16'h0029, 1);
        chk("clear_event", 16'h0001, {15'h0000, alert_line});
        rd(OFS_CONFIGURATION, 1, 1'h1, w);
        chk("clear_self_zero", 16'h0009, w);
        wr(OFS_CONFIGURATION, 16'h000B, 1);
        alarm_pulse();
        ara(8'hFF, ack, q);
        chk("ara_pol_high", 16'h0001, {15'h0000, ack});
        wr(OFS_CONFIGURATION, 16'h0008, 1);
        chk("cmp_follow", 16'h0000, {15'h0000, alert_line});
        ara(8'hFF, ack, q);
        chk("ara_cmp_mode", 16'h0001, {15'h0000, ack});
        @(negedge clk) alarm_event = 1'h0;
        repeat (5) @(negedge clk);
        chk("cmp_release", 16'h0001, {15'h0000, alert_line});
    endtask : test_alert
    // ************************************************************
    // Sequence, watchdog and verdict.
    // ************************************************************
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        rst_n = 1'h0;
        alarm_event = 1'h1;
        temp_value = 16'h0C3A;
        repeat (20) @(negedge clk);
        rst_n = 1'h1;
        repeat (8) @(negedge clk);
        test_defaults();
        test_write_read();
        test_access();
        test_timeout();
        test_alert();
        summarize();
    end
    initial begin
        repeat (90000) @(posedge clk);
        num_errors++;
        summarize();
    end
endmodule : tb
